// file: mpfc_pin_config.sv
// modem pin function configuration, two channels of four pins
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - bit 7 set disables pull-up; clear leaves pull-up enabled
// - bit 6 enables pull-down, but only while the pull-up is disabled
// - both pull settings ignored whenever the pin drives as any output
// - carrier pin: 00 input, 01 open-drain, 10 push-pull, 11 invalid
// - ring pin: 00 input, 01 open-drain, 10 push-pull, 11 invalid
// - ring bit 5 clear lets the pin wake the host if globally enabled
// - terminal-ready select: gpio in/od/pp, modem od, modem pp; rest invalid
// - set-ready: 00 in, 01 od, 10 pp, 11 modem input (not driven, active low)
module mpfc_pin_config
    import mpfc_pkg::*;
#(
    parameter int N_CH = MPFC_NCH
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [N_CH-1:0][MPFC_NPIN-1:0] gpio_drive_level,
    input wire logic [N_CH-1:0] terminal_ready_assert,
    input wire logic global_wake_en,
    input wire logic [N_CH-1:0][MPFC_NPIN-1:0] pin_in,
    output mpfc_pad_t [N_CH-1:0][MPFC_NPIN-1:0] pad_ctrl,
    output logic [N_CH-1:0][MPFC_NPIN-1:0] pin_level,
    output logic [N_CH-1:0] set_ready_active,
    output logic [N_CH-1:0] wake_req
);

    logic [7:0] cfg_r [N_CH][MPFC_NPIN];
    logic [N_CH-1:0][MPFC_NPIN-1:0] meta_r;
    logic [N_CH-1:0][MPFC_NPIN-1:0] sync_r;
    logic [7:0] rdata_nxt;

    // two-stage synchroniser on every pin input
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    // read decode, unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        for (int c = 0; c < N_CH; c++)
        begin
            for (int p = 0; p < MPFC_NPIN; p++)
            begin
                if (reg_addr == OFS_TABLE[c][p])
                begin
                    rdata_nxt = cfg_r[c][p];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rdata_nxt;
        end
    end

    genvar gc, gp;
    generate
        for (gc = 0; gc < N_CH; gc++)
        begin : g_ch
            logic sr_nxt;
            logic wake_nxt;

            for (gp = 0; gp < MPFC_NPIN; gp++)
            begin : g_pin
                mpfc_pad_t pad_nxt;
                logic drive;
                logic level;
                logic [7:0] cfg;

                assign cfg = cfg_r[gc][gp];

                // reserved bits are masked off; software keeps them zero
                always_ff @(posedge mclk or negedge arst_n)
                begin
                    if (!arst_n)
                    begin
                        cfg_r[gc][gp] <= CFG_RESET;
                    end
                    else if (reg_wr && reg_addr == OFS_TABLE[gc][gp])
                    begin
                        cfg_r[gc][gp] <= reg_wdata & CFG_MASK[gp];
                    end
                end

                // function select decode into drive and open-drain choice
                always_comb
                begin
                    drive = 1'b0;
                    level = gpio_drive_level[gc][gp];
                    pad_nxt.out = 1'b0;
                    pad_nxt.oe = 1'b0;
                    if (gp == PIN_TERM)
                    begin
                        case (cfg[2:0])
                            FN3_OD:
                            begin
                                drive = 1'b1;
                                pad_nxt.oe = ~level;
                            end
                            FN3_PP:
                            begin
                                drive = 1'b1;
                                pad_nxt.oe = 1'b1;
                                pad_nxt.out = level;
                            end
                            FN3_MODEM_OD:
                            begin
                                drive = 1'b1;
                                pad_nxt.oe = terminal_ready_assert[gc];
                            end
                            FN3_MODEM_PP:
                            begin
                                drive = 1'b1;
                                pad_nxt.oe = 1'b1;
                                pad_nxt.out = ~terminal_ready_assert[gc];
                            end
                            default:
                            begin
                                drive = 1'b0;
                            end
                        endcase
                    end
                    else
                    begin
                        // code 11 is never a drive code on any 2-bit pin
                        case (cfg[1:0])
                            FN2_OD:
                            begin
                                drive = 1'b1;
                                pad_nxt.oe = ~level;
                            end
                            FN2_PP:
                            begin
                                drive = 1'b1;
                                pad_nxt.oe = 1'b1;
                                pad_nxt.out = level;
                            end
                            default:
                            begin
                                drive = 1'b0;
                            end
                        endcase
                    end
                    pad_nxt.pull_up = ~drive
                        & ~cfg[BIT_PULL_HIGH_DISABLE];
                    pad_nxt.pull_down = ~drive & cfg[BIT_PULL_HIGH_DISABLE]
                        & cfg[BIT_PULL_LOW_ENABLE];
                end

                always_ff @(posedge mclk or negedge arst_n)
                begin
                    if (!arst_n)
                    begin
                        pad_ctrl[gc][gp] <= '0;
                        pin_level[gc][gp] <= 1'b0;
                    end
                    else
                    begin
                        pad_ctrl[gc][gp] <= pad_nxt;
                        pin_level[gc][gp] <= sync_r[gc][gp];
                    end
                end
            end

            // set-ready modem input, active low on the pin
            assign sr_nxt = (cfg_r[gc][PIN_SETRDY][1:0] == FN2_MODEM_IN)
                & ~sync_r[gc][PIN_SETRDY];
            // ring pin low wakes the host while an input and not blocked
            assign wake_nxt = global_wake_en
                & ~cfg_r[gc][PIN_RING][BIT_WAKE_SOURCE_BLOCK]
                & (cfg_r[gc][PIN_RING][1:0] == FN2_IN)
                & ~sync_r[gc][PIN_RING];

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    set_ready_active[gc] <= 1'b0;
                    wake_req[gc] <= 1'b0;
                end
                else
                begin
                    set_ready_active[gc] <= sr_nxt;
                    wake_req[gc] <= wake_nxt;
                end
            end
        end
    endgenerate

endmodule : mpfc_pin_config

`default_nettype wire

// file: mpfc_pkg.sv
// constants and types for the modem pin function configuration block
package mpfc_pkg;
    localparam int MPFC_NPIN = 4;
    localparam int MPFC_NCH = 2;
    // pin index inside a channel
    localparam int PIN_CARRIER = 0;
    localparam int PIN_RING = 1;
    localparam int PIN_TERM = 2;
    localparam int PIN_SETRDY = 3;
    // register offsets
    localparam logic [7:0] OFS_CARRIER_DETECT_PIN_CFG_CH0 = 8'h2a;
    localparam logic [7:0] OFS_RING_WAKE_PIN_CFG_CH0 = 8'h2b;
    localparam logic [7:0] OFS_TERMINAL_READY_PIN_CFG_CH0 = 8'h2c;
    localparam logic [7:0] OFS_SET_READY_PIN_CFG_CH0 = 8'h2d;
    localparam logic [7:0] OFS_CARRIER_DETECT_PIN_CFG_CH1 = 8'h3d;
    localparam logic [7:0] OFS_RING_WAKE_PIN_CFG_CH1 = 8'h3e;
    localparam logic [7:0] OFS_TERMINAL_READY_PIN_CFG_CH1 = 8'h3f;
    localparam logic [7:0] OFS_SET_READY_PIN_CFG_CH1 = 8'h40;
    localparam logic [7:0] OFS_TABLE [MPFC_NCH][MPFC_NPIN] = '{
        '{OFS_CARRIER_DETECT_PIN_CFG_CH0, OFS_RING_WAKE_PIN_CFG_CH0,
          OFS_TERMINAL_READY_PIN_CFG_CH0, OFS_SET_READY_PIN_CFG_CH0},
        '{OFS_CARRIER_DETECT_PIN_CFG_CH1, OFS_RING_WAKE_PIN_CFG_CH1,
          OFS_TERMINAL_READY_PIN_CFG_CH1, OFS_SET_READY_PIN_CFG_CH1}};
    // field positions
    localparam int BIT_PULL_HIGH_DISABLE = 7;
    localparam int BIT_PULL_LOW_ENABLE = 6;
    localparam int BIT_WAKE_SOURCE_BLOCK = 5;
    // implemented bits per pin, reserved bits read as zero
    localparam logic [7:0] CFG_MASK [MPFC_NPIN] = '{8'hc3, 8'he3, 8'hc7,
        8'hc3};
    localparam logic [7:0] CFG_RESET = 8'h00;
    // two-bit function selects
    localparam logic [1:0] FN2_IN = 2'h0;
    localparam logic [1:0] FN2_OD = 2'h1;
    localparam logic [1:0] FN2_PP = 2'h2;
    localparam logic [1:0] FN2_MODEM_IN = 2'h3;
    // three-bit function select of the terminal-ready pin
    localparam logic [2:0] FN3_IN = 3'h0;
    localparam logic [2:0] FN3_OD = 3'h1;
    localparam logic [2:0] FN3_PP = 3'h2;
    localparam logic [2:0] FN3_MODEM_OD = 3'h3;
    localparam logic [2:0] FN3_MODEM_PP = 3'h4;
    // pad control bundle of one pin
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_down;
    } mpfc_pad_t;
endpackage : mpfc_pkg

// file: mpfc_pin_config_checker.sv
// assertions on the modem pin configuration ports
`timescale 1ns/10ps
`default_nettype none
module mpfc_pin_config_checker
    import mpfc_pkg::*;
#(
    parameter int N_CH = MPFC_NCH
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic global_wake_en,
    input wire mpfc_pad_t [N_CH-1:0][MPFC_NPIN-1:0] pad_ctrl,
    input wire logic [N_CH-1:0] wake_req
);
    logic both_pull;
    logic out_pull;
    logic [7:0] mask_c;
    always_comb
    begin
        both_pull = 1'b0;
        out_pull = 1'b0;
        mask_c = 8'h00;
        for (int c = 0; c < N_CH; c++)
            for (int p = 0; p < MPFC_NPIN; p++)
            begin
                both_pull |= pad_ctrl[c][p].pull_up & pad_ctrl[c][p].pull_down;
                out_pull |= pad_ctrl[c][p].oe &
                    (pad_ctrl[c][p].pull_up | pad_ctrl[c][p].pull_down);
                if (reg_addr == OFS_TABLE[c][p])
                    mask_c = CFG_MASK[p];
            end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_wr;
        reg_wr && !reg_rd && mask_c != 8'h00;
    endsequence
    sequence s_rd_same;
        reg_rd && !reg_wr && $stable(reg_addr);
    endsequence
    a_pull_exclusive:
        assert property (!both_pull) else $error("both pulls on");
    a_out_no_pull:
        assert property (!out_pull) else $error("pull on a driven pin");
    a_wake_global:
        assert property ((!global_wake_en) [*4] |-> wake_req == '0)
        else $error("wake without global enable");
    a_wake_input:
        assert property (wake_req[0] |-> !pad_ctrl[0][PIN_RING].oe)
        else $error("wake while ring drives");
    a_rd_hold:
        assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_unmapped_zero:
        assert property (reg_rd && mask_c == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero:
        assert property (reg_rd |=> (reg_rdata & ~$past(mask_c)) == 8'h00)
        else $error("reserved bits read nonzero");
    a_write_readback:
        assert property (s_wr ##1 s_rd_same |=>
            reg_rdata == ($past(reg_wdata, 2) & $past(mask_c, 2)))
        else $error("readback differs");
endmodule : mpfc_pin_config_checker
bind mpfc_pin_config mpfc_pin_config_checker #(.N_CH(N_CH))
    mpfc_pin_config_checker_inst (.mclk, .arst_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .global_wake_en, .pad_ctrl, .wake_req);
`default_nettype wire

// file: mpfc_line_model.sv
// far-side line model for the modem control pins
`timescale 1ns/10ps
`default_nettype none
module mpfc_line_model
    import mpfc_pkg::*;
(
    input wire logic mclk,
    input wire mpfc_pad_t [1:0][3:0] pad_ctrl,
    input wire logic [1:0][3:0] ext_en,
    input wire logic [1:0][3:0] ext_lvl,
    output logic [1:0][3:0] pin_in
);
    logic flip = 1'b0;
    always_ff @(posedge mclk)
        flip <= ~flip;
    // device drive, then far end, then pulls, else floating
    always_comb
        for (int c = 0; c < 2; c++)
            for (int p = 0; p < 4; p++)
                pin_in[c][p] = pad_ctrl[c][p].oe ? pad_ctrl[c][p].out :
                    ext_en[c][p] ? ext_lvl[c][p] :
                    pad_ctrl[c][p].pull_up ? 1'b1 :
                    pad_ctrl[c][p].pull_down ? 1'b0 : flip;
endmodule : mpfc_line_model
`default_nettype wire

// file: modem_pin_function_config_bench.sv
// self-checking bench for the modem pin configuration block
`timescale 1ns/10ps
`default_nettype none
module modem_pin_function_config_bench
    import mpfc_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, global_wake_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic [1:0][3:0] gpio_drive_level = '0, ext_en = '0, ext_lvl = '0;
    logic [1:0][3:0] pin_in, pin_level;
    logic [1:0] terminal_ready_assert = '0, set_ready_active, wake_req;
    mpfc_pad_t [1:0][3:0] pad_ctrl;
    int num_errors = 0, num_checks = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    mpfc_pin_config mpfc_pin_config_inst (.mclk, .arst_n, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .gpio_drive_level,
        .terminal_ready_assert, .global_wake_en, .pin_in, .pad_ctrl,
        .pin_level, .set_ready_active, .wake_req);
    mpfc_line_model mpfc_line_model_inst (.mclk, .pad_ctrl, .ext_en,
        .ext_lvl, .pin_in);
    task automatic chk(input string n, input logic [7:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // must start in the time step of a rising edge
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    function automatic mpfc_pad_t exp_pad(int p, logic [7:0] c, logic l, t);
        logic [2:0] f;
        logic o;
        mpfc_pad_t x;
        f = (p == PIN_TERM) ? c[2:0] : {1'b0, c[1:0]};
        o = f == 3'h1 || f == 3'h2 ||
            (p == PIN_TERM && (f == 3'h3 || f == 3'h4));
        x.out = (f == 3'h2) ? l : (f == 3'h4) ? ~t : 1'b0;
        x.oe = (f == 3'h1) ? ~l : (f == 3'h2 || f == 3'h4) ? 1'b1 :
            (f == 3'h3 && p == PIN_TERM) ? t : 1'b0;
        x.pull_up = !o && !c[7];
        x.pull_down = !o && c[7] && c[6];
        return x;
    endfunction : exp_pad
    task automatic setp(input int c, p, input logic [7:0] v);
        wr(OFS_TABLE[c][p], v);
        rd(OFS_TABLE[c][p]);
        chk("readback", v & CFG_MASK[p], d);
        chk("pad", {4'h0, exp_pad(p, v, gpio_drive_level[c][p],
            terminal_ready_assert[c])}, {4'h0, pad_ctrl[c][p]});
    endtask : setp
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            close_out();
        end
    end
    initial
    begin
        void'($urandom(32'h2196));
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        for (int c = 0; c < 2; c++)
            for (int p = 0; p < 4; p++)
            begin
                @(posedge mclk);
                rd(OFS_TABLE[c][p]);
                chk("reset value", CFG_RESET, d);
                chk("reset pad", 8'h02, {4'h0, pad_ctrl[c][p]});
            end
        @(posedge mclk);
        rd(8'h2e);
        chk("unmapped", 8'h00, d);
        setp(0, PIN_CARRIER, 8'hfe);
        repeat (2)
            for (int c = 0; c < 2; c++)
                for (int p = 0; p < 4; p++)
                    for (int f = 0; f < 3; f++)
                    begin
                        @(posedge mclk);
                        gpio_drive_level <= 8'($urandom);
                        terminal_ready_assert <= 2'($urandom);
                        setp(c, p, (8'($urandom) & 8'hc0) | 8'(f) |
                            (p == PIN_RING ? 8'($urandom) & 8'h20 : 8'h00));
                    end
        for (int c = 0; c < 2; c++)
        begin
            @(posedge mclk);
            ext_en[c][PIN_SETRDY] <= 1'b1;
            setp(c, PIN_SETRDY, 8'h03);
            setp(c, PIN_TERM, 8'h03);
            @(posedge mclk);
            terminal_ready_assert[c] <= 1'b1;
            setp(c, PIN_TERM, 8'h04);
            wt(5);
            chk("set ready", 8'h01, {7'h0, set_ready_active[c]});
            // far end releases the line high: no longer active
            @(posedge mclk);
            ext_lvl[c][PIN_SETRDY] <= 1'b1;
            wt(5);
            chk("set ready idle", 8'h00,
                {7'h0, set_ready_active[c]});
            chk("set ready level", 8'h01,
                {7'h0, pin_level[c][PIN_SETRDY]});
        end
        @(posedge mclk);
        ext_en[0][PIN_RING] <= 1'b1;
        global_wake_en <= 1'b1;
        setp(0, PIN_RING, 8'h00);
        wt(5);
        chk("ring level", 8'h00, {7'h0, pin_level[0][PIN_RING]});
        chk("wake", 8'h01, {7'h0, wake_req[0]});
        setp(0, PIN_RING, 8'h20);
        wt(3);
        chk("wake blocked", 8'h00, {7'h0, wake_req[0]});
        close_out();
    end
endmodule : modem_pin_function_config_bench
`default_nettype wire
